// ===== fcl_consts.svh
// Constants for the FIR coefficient loader: control word fields, formats and counts.
// Assumes inclusion by bare name from the loader package and modules.
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH

`define FCL_CTRL1_ADDR       16'h0001
`define FCL_LOAD_REQ_BIT     15
`define FCL_RD_STAT_BIT      11
`define FCL_TAP_HI           8
`define FCL_TAP_LO           5
`define FCL_TAP_DEFAULT      4'h0
`define FCL_COEFS_PER_STEP   6
`define FCL_MAX_COEFS        48
`define FCL_COEF_BITS        27
`define FCL_MAG_BITS         26
`define FCL_PAD_BITS         5
`define FCL_STATUS_OK_BIT    7
`define FCL_IDX_W            6
`define FCL_FIFO_DEPTH       4

`endif

// ===== fcl_pkg.sv
// Types shared by the FIR coefficient loader files.
// Assumes the constants header is on the include path.
`include "fcl_consts.svh"
package fcl_pkg;
	typedef enum logic [2:0] {
		FCL_IDLE, FCL_DATA, FCL_HIGH, FCL_LOW, FCL_CSUM, FCL_FILL
	} fcl_state_t;
	typedef logic [`FCL_COEF_BITS-1:0] fcl_coef_t;
endpackage : fcl_pkg

// ===== fcl_fifo.sv
// Small synchronous FIFO carrying bus words into the loader.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_consts.svh"
module fcl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = `FCL_FIFO_DEPTH
) (
	input  wire logic             sys_clk,   // Converter clock.
	input  wire logic             nrst,      // Asynchronous reset, active low.
	input  wire logic             inValid,   // Word offered.
	output logic                  inReady,   // Room available.
	input  wire logic [WIDTH-1:0] inData,    // Word in.
	output logic                  outValid,  // Word available.
	input  wire logic             outReady,  // Consumer takes the word.
	output logic      [WIDTH-1:0] outData    // Registered head word.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [AW:0]      count_reg, count_next;
	logic [WIDTH-1:0] outData_reg, outData_next;
	logic             push, pop;

	// Head word is registered so the data output comes from a flip-flop.
	always_comb begin
		push         = inValid && inReady;
		pop          = outValid && outReady;
		wrPtr_next   = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
		rdPtr_next   = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
		count_next   = (AW+1)'(count_reg + (AW+1)'(push) - (AW+1)'(pop));
		outData_next = mem_reg[rdPtr_next];
		if (push && (wrPtr_reg == rdPtr_next)) begin
			outData_next = inData; // Write-through when the slot being read is written now.
		end
	end

	// Pointers, count and registered head word.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_reg   <= '0;
			rdPtr_reg   <= '0;
			count_reg   <= '0;
			outData_reg <= '0;
		end else begin
			wrPtr_reg   <= wrPtr_next;
			rdPtr_reg   <= rdPtr_next;
			count_reg   <= count_next;
			outData_reg <= outData_next;
		end
	end

	// Memory array has no reset; its content is only read once written.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_reg[wrPtr_reg] <= inData;
		end
	end

	assign inReady  = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = outData_reg;
endmodule : fcl_fifo
`default_nettype wire

// ===== fcl_loader.sv
// FIR coefficient loader: takes address/data word pairs from the parallel bus,
// catches control register 1 writes and collects user coefficients and checksum.
// Assumes the host keeps the download order; the filter datapath reads coefStore.
// Operation
// (RULE_01) Each coefficient is 27 bits: one sign bit, 26 magnitude bits.
// (RULE_02) Coefficient padded to 32 bits, sent as upper word then lower word.
// (RULE_03) Checksum is 16-bit sum of all four bytes of every coefficient.
// (RULE_04) Host writes the checksum word right after the last coefficient word.
// (RULE_05) Device recomputes checksum, sets download-ok flag when both agree.
// (RULE_06) Download begins with control register 1 load request and tap count.
// (RULE_07) Coefficients go from centre of symmetry outward, one at a time.
// (RULE_08) Per coefficient, upper word first, lower word second, repeated for all.
// (RULE_09) Tap code 0000 is default; odd codes give 6 to 48 coefficients.
// (RULE_10) User coefficients are volatile; reset restores the default filter.
// (RULE_11) After checksum, unused slots are zeroed; host waits for the fill.
// (RULE_12) Host confirms download through the status flag.
// (RULE_13) Status readback bit set with tap and decimation kept; flag at bit 7.
// (RULE_14) A register write is an address word then a data word; CR1 is 0x0001.
// (RULE_15) Under load request, data writes are coefficients; request self-clears.
// (RULE_16) Tap code lives in CR1 bits 8 to 5, set with the load request.
// (RULE_17) Only half the taps are sent; the datapath mirrors them.
// (RULE_18) Checksum accumulator keeps only the low 16 bits.
`timescale 1ns/100ps
`default_nettype none
`include "fcl_consts.svh"
module fcl_loader
	import fcl_pkg::*;
#(
	parameter int MAX_COEFS = `FCL_MAX_COEFS
) (
	input  wire logic                      sys_clk,         // Converter clock, 10 MHz.
	input  wire logic                      nrst,            // Asynchronous reset, active low.
	input  wire logic                      busWrite,        // One-cycle bus word strobe.
	input  wire logic [15:0]               busData,         // Bus word.
	output logic                           busReady,        // Loader can take a word.
	output logic [15:0]                    ctrl1Value,      // Last control register 1 data.
	output logic                           readStatusReq,   // Status readback pending.
	output logic                           userFilterActive,// User coefficients in use.
	output logic [`FCL_TAP_HI-`FCL_TAP_LO:0] tapCountCode,  // Tap code of stored filter.
	output logic                           loadBusy,        // Download or fill in progress.
	output logic                           downloadOk,      // Checksum matched.
	output logic [15:0]                    statusWord,      // Status word, ok flag at bit 7.
	input  wire logic [`FCL_IDX_W-1:0]     coefIndex,       // Coefficient read index.
	output logic [`FCL_COEF_BITS-1:0]      coefData         // Registered coefficient.
);
	localparam int TW = `FCL_TAP_HI - `FCL_TAP_LO + 1;

	fcl_state_t        state_reg, state_next;
	logic [15:0]       ctrl1_reg, ctrl1_next;
	logic [15:0]       hiWord_reg, hiWord_next;
	logic [15:0]       sum_reg, sum_next;
	logic [`FCL_IDX_W-1:0] idx_reg, idx_next, total_reg, total_next;
	logic [TW-1:0]     tap_reg, tap_next, pendTap_reg, pendTap_next;
	logic              ok_reg, ok_next, user_reg, user_next, rdStat_reg, rdStat_next;
	logic [`FCL_COEF_BITS-1:0] coefStore [MAX_COEFS];
	logic [`FCL_COEF_BITS-1:0] coefData_reg;
	logic              wrEn;
	logic [`FCL_IDX_W-1:0] wrIdx;
	logic [`FCL_COEF_BITS-1:0] wrData;
	logic              fifoValid, fifoTake;
	logic [15:0]       fifoData;

	// Number of coefficients for a tap code; every even code, 0 included, gives zero.
	function automatic logic [`FCL_IDX_W-1:0] coefCount(input logic [TW-1:0] code);
		logic [`FCL_IDX_W-1:0] n;
		n = '0;
		if (code[0]) begin
			n = `FCL_IDX_W'((code + 1'b1) / 2 * `FCL_COEFS_PER_STEP); // RULE_09
		end
		return n;
	endfunction : coefCount

	// Byte sum of one padded coefficient; upper byte holds the pad bits and coefficient bits 26 to 24.
	// Each byte is widened first so the carries of the four-byte sum are not lost.
	function automatic logic [15:0] byteSum(input logic [15:0] hi, input logic [15:0] lo);
		return 16'(hi[15:8]) + 16'(hi[7:0]) + 16'(lo[15:8]) + 16'(lo[7:0]); // RULE_03
	endfunction : byteSum

	// Bus words pass a FIFO so the loader may stall during zero fill without losing writes.
	fcl_fifo #(.WIDTH(16), .DEPTH(`FCL_FIFO_DEPTH)) inFifo (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.inValid  (busWrite),
		.inReady  (busReady),
		.inData   (busData),
		.outValid (fifoValid),
		.outReady (fifoTake),
		.outData  (fifoData)
	);

	// Sequencer: address/data decode, coefficient pairs, checksum and zero fill.
	always_comb begin
		state_next   = state_reg;
		ctrl1_next   = ctrl1_reg;
		hiWord_next  = hiWord_reg;
		sum_next     = sum_reg;
		idx_next     = idx_reg;
		total_next   = total_reg;
		tap_next     = tap_reg;
		pendTap_next = pendTap_reg;
		ok_next      = ok_reg;
		user_next    = user_reg;
		rdStat_next  = rdStat_reg;
		wrEn         = 1'b0;
		wrIdx        = idx_reg;
		wrData       = '0;
		fifoTake     = fifoValid && (state_reg != FCL_FILL);
		case (state_reg)
			FCL_IDLE: begin
				if (fifoValid) begin
					state_next = (fifoData == `FCL_CTRL1_ADDR) ? FCL_DATA : FCL_IDLE; // RULE_14
				end
			end
			FCL_DATA: begin
				if (fifoValid) begin
					// Self-clearing bits are not kept in the stored value.
					ctrl1_next  = {7'h00, fifoData[`FCL_TAP_HI:0]};
					rdStat_next = fifoData[`FCL_RD_STAT_BIT]; // RULE_13
					state_next  = FCL_IDLE;
					if (fifoData[`FCL_LOAD_REQ_BIT] &&
					    coefCount(fifoData[`FCL_TAP_HI:`FCL_TAP_LO]) != '0) begin // RULE_15
						pendTap_next = fifoData[`FCL_TAP_HI:`FCL_TAP_LO]; // RULE_16
						total_next   = coefCount(fifoData[`FCL_TAP_HI:`FCL_TAP_LO]);
						idx_next     = '0;
						sum_next     = '0;
						ok_next      = 1'b0;
						state_next   = FCL_HIGH;
					end
				end
			end
			FCL_HIGH: begin
				if (fifoValid) begin
					hiWord_next = fifoData; // RULE_08
					state_next  = FCL_LOW;
				end
			end
			FCL_LOW: begin
				if (fifoValid) begin
					wrEn   = 1'b1;
					wrData = {hiWord_reg[`FCL_MAG_BITS-16:0], fifoData}; // RULE_01 RULE_02
					sum_next = 16'(sum_reg + byteSum(hiWord_reg, fifoData)); // RULE_18
					idx_next = `FCL_IDX_W'(idx_reg + 1'b1); // RULE_07
					state_next = (idx_next == total_reg) ? FCL_CSUM : FCL_HIGH; // RULE_04
				end
			end
			FCL_CSUM: begin
				if (fifoValid) begin
					ok_next    = (fifoData == sum_reg); // RULE_05
					user_next  = 1'b1;
					tap_next   = pendTap_reg;
					state_next = FCL_FILL;
				end
			end
			FCL_FILL: begin
				// One unused slot zeroed per clock; the host wait covers this.
				if (idx_reg >= `FCL_IDX_W'(MAX_COEFS)) begin
					state_next = FCL_IDLE;
				end else begin
					wrEn     = 1'b1; // RULE_11
					wrData   = '0;
					idx_next = `FCL_IDX_W'(idx_reg + 1'b1);
				end
			end
			default: state_next = FCL_IDLE;
		endcase
	end

	// Control state; reset drops user coefficients back to the default filter.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg   <= FCL_IDLE;
			ctrl1_reg   <= 16'h0000;
			hiWord_reg  <= 16'h0000;
			sum_reg     <= 16'h0000;
			idx_reg     <= '0;
			total_reg   <= '0;
			tap_reg     <= `FCL_TAP_DEFAULT;
			pendTap_reg <= `FCL_TAP_DEFAULT;
			ok_reg      <= 1'b0;
			user_reg    <= 1'b0; // RULE_10
			rdStat_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			ctrl1_reg   <= ctrl1_next;
			hiWord_reg  <= hiWord_next;
			sum_reg     <= sum_next;
			idx_reg     <= idx_next;
			total_reg   <= total_next;
			tap_reg     <= tap_next;
			pendTap_reg <= pendTap_next;
			ok_reg      <= ok_next;
			user_reg    <= user_next;
			rdStat_reg  <= rdStat_next;
		end
	end

	// Half-filter store; the datapath mirrors it for the full response.
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			coefStore[wrIdx] <= wrData; // RULE_17
		end
		coefData_reg <= coefStore[coefIndex];
	end

	assign ctrl1Value       = ctrl1_reg;
	assign readStatusReq    = rdStat_reg;
	assign userFilterActive = user_reg;
	assign tapCountCode     = tap_reg;
	assign loadBusy         = (state_reg != FCL_IDLE) && (state_reg != FCL_DATA);
	assign downloadOk       = ok_reg; // RULE_12
	assign statusWord       = 16'(ok_reg) << `FCL_STATUS_OK_BIT; // RULE_13
	assign coefData         = coefData_reg;
endmodule : fcl_loader
`default_nettype wire

// ===== fcl_loader_sva.sv
// Checker for the coefficient loader, bound to its top ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module fcl_loader_chk #(
	parameter int MAX_COEFS = 48
) (
	input wire logic        sys_clk,          // Clock.
	input wire logic        nrst,             // Reset.
	input wire logic        busWrite,         // Strobe.
	input wire logic [15:0] busData,          // Word.
	input wire logic        busReady,         // Room.
	input wire logic [15:0] ctrl1Value,       // Control copy.
	input wire logic        readStatusReq,    // Readback.
	input wire logic        userFilterActive, // User filter.
	input wire logic [3:0]  tapCountCode,     // Tap code.
	input wire logic        loadBusy,         // Busy.
	input wire logic        downloadOk,       // Sum matched.
	input wire logic [15:0] statusWord,       // Status.
	input wire logic [5:0]  coefIndex,        // Index.
	input wire logic [26:0] coefData          // Coefficient.
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// Status and control shapes; a stuck bit in either shows at once.
	chk_status_bit: assert property (statusWord == {8'h00, downloadOk, 7'h00})
		else $error("status word does not carry the flag alone");
	chk_ctrl_selfclr: assert property (ctrl1Value[15:9] == 7'h00)
		else $error("self-clearing control bits stayed set");
	chk_reset_clear: assert property ($rose(nrst) |-> !downloadOk && tapCountCode == 4'h0)
		else $error("user filter survived reset");
	chk_tap_legal: assert property (tapCountCode == 4'h0 || tapCountCode[0])
		else $error("even tap code stored");
	chk_ok_user: assert property (downloadOk |-> userFilterActive)
		else $error("ok flag without a received checksum");
	// The FIFO refuses only during the zero fill and the one cycle after it.
	chk_refuse_fill: assert property (!busReady |-> loadBusy || $past(loadBusy))
		else $error("word refused outside the fill");
	chk_busy_bound: assert property ($rose(loadBusy) |-> ##[1:1000] !loadBusy)
		else $error("load never finished");
	chk_ok_clear: assert property ($fell(downloadOk) |-> ##[0:2] loadBusy)
		else $error("ok flag dropped without a download");
	cov_ok: cover property ($rose(downloadOk));
	cov_full: cover property (!busReady);
	cov_stat: cover property ($rose(readStatusReq));
endmodule : fcl_loader_chk
bind fcl_loader fcl_loader_chk #(.MAX_COEFS(MAX_COEFS)) i_fcl_loader_chk (.sys_clk(sys_clk),
	.nrst(nrst), .busWrite(busWrite), .busData(busData), .busReady(busReady),
	.ctrl1Value(ctrl1Value), .readStatusReq(readStatusReq), .loadBusy(loadBusy),
	.userFilterActive(userFilterActive), .tapCountCode(tapCountCode),
	.downloadOk(downloadOk), .statusWord(statusWord), .coefIndex(coefIndex),
	.coefData(coefData));
`default_nettype wire

// ===== fcl_host.sv
// Host model: plays queued words onto the loader's word strobe.
// Assumes the loader samples busWrite and busReady on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module fcl_host (
	input  wire logic        sys_clk,  // Clock.
	input  wire logic        busReady, // Loader has room.
	input  wire logic [3:0]  gap,      // Idle cycles after each word.
	output logic             busWrite, // Strobe.
	output logic      [15:0] busData   // Word.
);
	logic [15:0] q[$];
	logic        taken;
	int          idle;
	// Words leave in queue order, so the caller fixes the download order.
	task send(input logic [15:0] w);
		q.push_back(w);
	endtask : send
	initial begin
		busWrite = 1'b0;
		busData = 16'h0000;
		idle = 0;
	end
	// A word counts as sent only on an edge that also saw room.
	always @(posedge sys_clk) taken <= busWrite && busReady;
	// A refused word is held; a released bus toggles so stale data cannot pass.
	always @(negedge sys_clk) begin
		if (busWrite && !taken) begin
			busWrite <= 1'b1;
		end else if (q.size() != 0 && idle == 0) begin
			busWrite <= 1'b1;
			busData <= q.pop_front();
			idle <= gap;
		end else begin
			busWrite <= 1'b0;
			busData <= ~busData;
			idle <= (idle != 0) ? idle - 1 : 0;
		end
	end
endmodule : fcl_host
`default_nettype wire

// ===== fcl_loader_tb.sv
// Testbench for the coefficient loader: all tap codes, fill, bad sum, reset.
// Assumes the loader, its checker and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module fcl_loader_tb;
	logic        sys_clk, nrst, busWrite, busReady, readStatusReq, userFilterActive;
	logic        loadBusy, downloadOk;
	logic [15:0] busData, ctrl1Value, statusWord;
	logic [3:0]  tapCountCode, gap;
	logic [5:0]  coefIndex;
	logic [26:0] coefData;
	int          n_errors, checks, sawFull;
	fcl_loader i_fcl_loader (.sys_clk(sys_clk), .nrst(nrst), .busWrite(busWrite),
		.busData(busData), .busReady(busReady), .ctrl1Value(ctrl1Value),
		.readStatusReq(readStatusReq), .userFilterActive(userFilterActive),
		.tapCountCode(tapCountCode), .loadBusy(loadBusy), .downloadOk(downloadOk),
		.statusWord(statusWord), .coefIndex(coefIndex), .coefData(coefData));
	fcl_host i_fcl_host (.sys_clk(sys_clk), .busReady(busReady), .gap(gap),
		.busWrite(busWrite), .busData(busData));
	// Clock, and a count of edges where the FIFO refused.
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) if (nrst && busReady === 1'b0) sawFull++;
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk
	task close_out();
		$display("Counts: %0d comparisons, %0d mismatches", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// Coefficient pattern; sign follows the index so both signs occur.
	function logic [26:0] coefOf(input int k);
		return {k[0], 26'(k * 32'h00135B7 + 32'h02A5C3F1)};
	endfunction : coefOf
	// Waits until the host queue drains and the loader is idle, twice over.
	task settle();
		int t;
		t = 0;
		repeat (2) begin
			while ((i_fcl_host.q.size() != 0 || busWrite || loadBusy) && t < 900) begin
				@(negedge sys_clk);
				t++;
			end
			repeat (4) @(negedge sys_clk);
		end
		chk(t < 900, 1'b1, "settle time");
	endtask : settle
	// One download; bad spoils the checksum, tail queues readbacks behind it.
	task load(input logic [3:0] code, input logic [15:0] bad, input bit tail);
		logic [31:0] p;
		logic [15:0] sum, cr;
		logic        okExp;
		logic [3:0]  tapExp;
		int          n;
		n = code[0] ? (int'(code) + 1) * 3 : 0;
		cr = 16'h0019 | {7'h00, code, 5'h00};
		okExp = (n == 0) ? downloadOk : (bad == 16'h0000);
		tapExp = (n == 0) ? tapCountCode : code;
		sum = 16'h0000;
		i_fcl_host.send(16'h0001);
		i_fcl_host.send(cr | 16'h8000);
		for (int k = 0; k < n; k++) begin
			p = {5'h00, coefOf(k)};
			sum = sum + p[31:24] + p[23:16] + p[15:8] + p[7:0];
			i_fcl_host.send(p[31:16]);
			i_fcl_host.send(p[15:0]);
		end
		i_fcl_host.send(sum ^ bad);
		repeat (tail ? 3 : 0) begin
			i_fcl_host.send(16'h0001);
			i_fcl_host.send(cr | 16'h0800);
		end
		settle();
		chk(downloadOk, okExp, "ok flag");
		chk(statusWord, {8'h00, okExp, 7'h00}, "status word");
		chk(tapCountCode, tapExp, "tap code");
		chk(ctrl1Value, cr, "control copy");
		chk(readStatusReq, tail, "readback request");
		for (int k = 0; k < 48 && n != 0 && bad == 16'h0000; k++) begin
			coefIndex = 6'(k);
			@(negedge sys_clk);
			chk(coefData, (k < n) ? coefOf(k) : 27'h0000000, "coefficient");
		end
		if (n != 0) chk(userFilterActive, 1'b1, "user filter");
	endtask : load
	task cleared(input string name);
		chk(downloadOk, 1'b0, "ok after reset");
		chk(userFilterActive, 1'b0, "user filter after reset");
		chk(tapCountCode, 4'h0, "tap after reset");
		$display("test %s done", name);
	endtask : cleared
	// Every tap code in turn; even codes must leave the stored filter alone.
	task t_all_codes();
		for (int c = 0; c < 16; c++) begin
			gap = 4'(c % 3);
			load(4'(c), 16'h0000, 1'b0);
		end
		$display("test all_codes done");
	endtask : t_all_codes
	// Readbacks queued behind a short filter must stall on the full FIFO.
	task t_fill_refuse();
		gap = 4'h0;
		sawFull = 0;
		load(4'h1, 16'h0000, 1'b1);
		chk(sawFull != 0, 1'b1, "fifo refusal");
		load(4'hB, 16'h0100, 1'b0);
		$display("test fill_refuse_bad_sum done");
	endtask : t_fill_refuse
	initial begin
		nrst = 1'b0;
		coefIndex = 6'h00;
		gap = 4'h0;
		repeat (5) @(negedge sys_clk);
		nrst = 1'b1;
		cleared("reset_values");
		t_all_codes();
		t_fill_refuse();
		load(4'h3, 16'h0000, 1'b0);
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		cleared("reset_clears");
		close_out();
	end
	// Watchdog well beyond the few thousand cycles the tests take.
	initial begin
		#(100 * 20000);
		n_errors++;
		close_out();
	end
endmodule : fcl_loader_tb
`default_nettype wire
